// ---- rtl/stc_pkg.sv ----
// Constants for the seconds counter with alarm: register map, field positions, reset values.
// Assumes a 20 MHz bus clock and a slow clock that arrives on a pin.
// Behaviour
// RULE1: Prescaler field sets slow clock periods per increment; zero means 65536 periods.
// RULE2: Nonzero prescaler value increments the counter once every that many slow periods.
// RULE3: Mode bit 16 lets a set alarm flag drive the interrupt.
// RULE4: Mode bit 17 lets a set increment flag drive the interrupt.
// RULE5: Writing one to mode bit 18 restarts the divider and clears the counter.
// RULE6: Alarm fires when the counter equals the programmed alarm value plus one.
// RULE7: Value register reads return the present 32-bit count.
// RULE8: Status bit 0 reads one if an alarm happened since the last status read.
// RULE9: Status bit 1 reads one if the counter advanced since the last status read.
// RULE10: The counter is a 32-bit up counter that wraps to zero.
// RULE11: A match sets the alarm flag; a status read clears both flags.
// RULE12: After reset the alarm register holds all ones.
// RULE13: Software reads the value register until two consecutive reads agree.
// RULE14: Interrupt is OR of enabled flags; a set during a status read wins.
// RULE15: Slow clock events are synchronised into the bus clock before updating flags.
package stc_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_MODE = 4'h0;
  localparam logic [3:0] OFF_ALARM = 4'h4;
  localparam logic [3:0] OFF_VALUE = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hc;
  localparam int BIT_ALARM_IE = 16;
  localparam int BIT_INC_IE = 17;
  localparam int BIT_RESTART = 18;
  localparam int BIT_ALARM_FLAG = 0;
  localparam int BIT_INC_FLAG = 1;
  localparam logic [15:0] PERIOD_RESET = 16'h8000;
  localparam logic [16:0] PERIOD_ZERO = 17'h10000;
  localparam logic [31:0] ALARM_RESET = 32'hffffffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : stc_pkg

// ---- rtl/stc_top.sv ----
// Seconds counter with alarm behind an AXI4-Lite slave.
// Assumes slow_clock is a free-running pin, far slower than aclk, sampled through two flip-flops.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module stc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow_clock,
  input wire logic [stc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [stc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // Write channel progress: which halves of a write are held, then the response.
  typedef enum logic [2:0] {
    WR_IDLE,
    WR_GOT_ADDR,
    WR_GOT_DATA,
    WR_BOTH,
    WR_RESP
  } stc_wr_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic [15:0] presc_cnt;
    logic [31:0] current_count;
    logic [15:0] prescale_period;
    logic alarm_irq_enable;
    logic increment_irq_enable;
    logic [31:0] alarm_value;
    logic alarm_flag;
    logic increment_flag;
    stc_wr_state_t wr_state;
    logic [stc_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } stc_state_t;

  stc_state_t q;
  stc_state_t next_q;

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] stc_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : stc_merge

  logic slow_tick;
  logic aw_take;
  logic w_take;
  logic [stc_pkg::ADDR_W-1:0] wr_offset;
  logic [stc_pkg::ADDR_W-1:0] rd_offset;
  logic sel_mode_wr;
  logic sel_alarm_wr;
  logic [31:0] status_word;
  logic [31:0] alarm_target;
  logic do_write;
  logic do_read;
  logic status_read;
  logic restart;
  logic [16:0] period_eff;
  logic [16:0] presc_next;
  logic [31:0] mode_word;
  logic [31:0] merged;
  logic [31:0] count_after;
  logic count_changed;
  logic inc_event;
  logic alarm_event;

  assign s_axi_awready = (q.wr_state == WR_IDLE) || (q.wr_state == WR_GOT_DATA);
  assign s_axi_wready = (q.wr_state == WR_IDLE) || (q.wr_state == WR_GOT_ADDR);
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid = (q.wr_state == WR_RESP);
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign irq = (q.alarm_flag && q.alarm_irq_enable) || (q.increment_flag && q.increment_irq_enable); // [RULE3] [RULE4] [RULE14]

  always_comb begin
    next_q = q;
    // Rising edges of the resynchronised slow clock drive the divider.
    next_q.sync1 = slow_clock;
    next_q.sync2 = q.sync1;
    next_q.sync3 = q.sync2;
    slow_tick = q.sync2 && !q.sync3; // [RULE15]

    mode_word = 32'h0;
    mode_word[15:0] = q.prescale_period;
    mode_word[stc_pkg::BIT_ALARM_IE] = q.alarm_irq_enable;
    mode_word[stc_pkg::BIT_INC_IE] = q.increment_irq_enable;

    // Write channel: address and data are taken in either order, then applied once both are held.
    aw_take = s_axi_awvalid && s_axi_awready;
    w_take = s_axi_wvalid && s_axi_wready;
    if (aw_take) begin
      next_q.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end
    do_write = 1'b0;
    unique case (q.wr_state)
      WR_IDLE: begin
        if (aw_take && w_take) begin
          next_q.wr_state = WR_BOTH;
        end else if (aw_take) begin
          next_q.wr_state = WR_GOT_ADDR;
        end else if (w_take) begin
          next_q.wr_state = WR_GOT_DATA;
        end
      end
      WR_GOT_ADDR: begin
        if (w_take) begin
          next_q.wr_state = WR_BOTH;
        end
      end
      WR_GOT_DATA: begin
        if (aw_take) begin
          next_q.wr_state = WR_BOTH;
        end
      end
      WR_BOTH: begin
        do_write = 1'b1;
        next_q.wr_state = WR_RESP;
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_q.wr_state = WR_IDLE;
        end
      end
      default: begin
        next_q.wr_state = WR_IDLE;
      end
    endcase
    wr_offset = {q.aw_addr[stc_pkg::ADDR_W-1:2], 2'b00};
    sel_mode_wr = do_write && (wr_offset == stc_pkg::OFF_MODE);
    sel_alarm_wr = do_write && (wr_offset == stc_pkg::OFF_ALARM);
    restart = 1'b0;
    merged = stc_merge(mode_word, q.w_data, q.w_strb);
    if (do_write) begin
      next_q.bresp = stc_pkg::RESP_OKAY;
    end
    if (sel_mode_wr) begin
      next_q.prescale_period = merged[15:0];
      next_q.alarm_irq_enable = merged[stc_pkg::BIT_ALARM_IE];
      next_q.increment_irq_enable = merged[stc_pkg::BIT_INC_IE];
      restart = q.w_strb[2] && q.w_data[stc_pkg::BIT_RESTART]; // [RULE5]
    end
    if (sel_alarm_wr) begin
      next_q.alarm_value = stc_merge(q.alarm_value, q.w_data, q.w_strb);
    end

    // Divider and counter.
    period_eff = (q.prescale_period == 16'h0) ? stc_pkg::PERIOD_ZERO : {1'b0, q.prescale_period}; // [RULE1]
    presc_next = {1'b0, q.presc_cnt} + 17'h1;
    inc_event = 1'b0;
    count_after = q.current_count;
    if (restart) begin
      next_q.presc_cnt = 16'h0;
      count_after = 32'h0;
    end else if (slow_tick) begin
      if (presc_next >= period_eff) begin // [RULE2]
        next_q.presc_cnt = 16'h0;
        count_after = q.current_count + 32'h1; // [RULE10]
        inc_event = 1'b1;
      end else begin
        next_q.presc_cnt = presc_next[15:0];
      end
    end
    next_q.current_count = count_after;
    count_changed = restart || inc_event;
    alarm_target = q.alarm_value + 32'h1;
    alarm_event = count_changed && (count_after == alarm_target); // [RULE6] [RULE11]

    // Read channel: one-cycle answer; a status read clears the flags.
    do_read = s_axi_arvalid && s_axi_arready;
    rd_offset = {s_axi_araddr[stc_pkg::ADDR_W-1:2], 2'b00};
    status_read = 1'b0;
    status_word = 32'h0;
    status_word[stc_pkg::BIT_ALARM_FLAG] = q.alarm_flag; // [RULE8]
    status_word[stc_pkg::BIT_INC_FLAG] = q.increment_flag; // [RULE9]
    if (do_read) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = stc_pkg::RESP_OKAY;
      next_q.rdata = 32'h0;
      unique case (rd_offset)
        stc_pkg::OFF_MODE: begin
          next_q.rdata = mode_word;
        end
        stc_pkg::OFF_ALARM: begin
          next_q.rdata = q.alarm_value;
        end
        stc_pkg::OFF_VALUE: begin
          next_q.rdata = q.current_count; // [RULE7] [RULE13]
        end
        stc_pkg::OFF_STATUS: begin
          next_q.rdata = status_word;
          status_read = 1'b1;
        end
        default: begin
          next_q.rresp = stc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end

    // Sticky flags: the set outranks the clear from a status read.
    next_q.alarm_flag = alarm_event || (q.alarm_flag && !status_read); // [RULE11] [RULE14]
    next_q.increment_flag = inc_event || (q.increment_flag && !status_read); // [RULE9] [RULE14]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.prescale_period <= stc_pkg::PERIOD_RESET;
      q.alarm_value <= stc_pkg::ALARM_RESET; // [RULE12]
    end else begin
      q <= next_q;
    end
  end

endmodule : stc_top

// ---- tb/stc_assertions.sv ----
// Checker for the stc_top bus handshakes and interrupt level.
// Sees only the top ports; bound below.
`timescale 1ns/100ps
module stc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_read_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read not answered");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  chk_rresp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0) else $error("read resp bad");
  chk_write_answer: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  chk_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && s_axi_bresp == 2'h0)
    else $error("write taken early");
  chk_irq_reset: assert property ($rose(aresetn) |-> !irq) else $error("irq after reset");
  chk_irq_sticky: assert property (irq && !s_axi_arvalid && s_axi_awready |=> irq)
    else $error("irq fell alone");
endmodule : stc_chk
bind stc_top stc_chk stc_chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

// ---- tb/stc_top_tb.sv ----
// Self-checking bench for stc_top against a counting model.
// Drives slow_clock and the AXI4-Lite port itself.
`timescale 1ns/100ps
module stc_top_tb;
  logic aclk = 1'b0, aresetn = 1'b0, slow_clock = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, flg = 2'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lfsr = 32'h63, alm = 32'hffffffff, mode = 32'h8000, cnt = 32'h0;
  int fails = 0, checks_done = 0, cyc = 0, dv = 0, per = 32768, k;
  stc_top stc_top_i (.aclk, .aresetn, .slow_clock, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  always #25 aclk = ~aclk;
  task automatic conclude;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit pa = 1, pw = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) pa = 0;
      if (s_axi_wready) pw = 0;
      if (!pa) s_axi_awvalid <= 1'b0;
      if (!pw) s_axi_wvalid <= 1'b0;
    end while (pa || pw);
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [31:0] exp, input string nm);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(nm, s_axi_rdata, exp);
    if (a == 4'hc) flg = 2'h0;
  endtask : rc
  task automatic tick(input int n);
    repeat (n) begin
      slow_clock <= 1'b1;
      repeat (4) @(posedge aclk);
      slow_clock <= 1'b0;
      repeat (4) @(posedge aclk);
      dv++;
      if (dv >= per) begin
        dv = 0;
        cnt++;
        flg[1] = 1'b1;
        if (cnt == alm + 32'h1) flg[0] = 1'b1;
      end
    end
  endtask : tick
  task automatic setmode(input logic [31:0] d);
    wr(4'h0, d);
    mode = d & 32'h3ffff;
    per = (d[15:0] == 16'h0) ? 65536 : int'(d[15:0]);
    if (d[18]) begin
      dv = 0;
      cnt = 32'h0;
      if (cnt == alm + 32'h1) flg[0] = 1'b1;
    end
  endtask : setmode
  task automatic ci;
    @(negedge aclk);
    chk("irq", {31'h0, irq}, {31'h0, (flg[0] & mode[16]) | (flg[1] & mode[17])});
    @(posedge aclk);
  endtask : ci
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(4'h0, mode, "mode");
    rc(4'h4, alm, "alarm");
    rc(4'h8, cnt, "value");
    rc(4'hc, 32'h0, "status");
    $display("test 1 done");
    alm = 32'h3;
    wr(4'h4, alm);
    rc(4'h4, alm, "alarm");
    setmode(32'h00060003);
    rc(4'h0, mode, "mode");
    tick(6);
    rc(4'h8, cnt, "value");
    ci();
    rc(4'hc, {30'h0, flg}, "status");
    ci();
    setmode(32'h00010003);
    tick(6);
    ci();
    rc(4'hc, {30'h0, flg}, "status");
    setmode(32'h00040000);
    tick(4);
    rc(4'h8, cnt, "value");
    $display("test 2 done");
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      setmode(32'h00070000 | (lfsr % 5 + 1));
      k = lfsr[7:4];
      tick(k);
      rc(4'h8, cnt, "value");
      rc(4'h8, cnt, "value again");
      ci();
      rc(4'hc, {30'h0, flg}, "status");
    end
    $display("test 3 done");
    conclude();
  end
endmodule : stc_top_tb
